// file: hdl/pcb_pkg.sv
package pcb_pkg;

    // ------------------------------------------------------------------
    // Configuration offsets (byte address of each field)
    // ------------------------------------------------------------------
    localparam logic [11:0] PCB_OFS_CLASS_AND_REVISION  = 12'h008;
    localparam logic [11:0] PCB_OFS_CACHE_LINE_SIZE     = 12'h00c;
    localparam logic [11:0] PCB_OFS_PRIMARY_LAT_TIMER   = 12'h00d;
    localparam logic [11:0] PCB_OFS_HEADER_TYPE         = 12'h00e;
    localparam logic [11:0] PCB_OFS_SELF_TEST           = 12'h00f;
    localparam logic [11:0] PCB_OFS_CONTROL_WINDOW_BASE = 12'h010;

    // ------------------------------------------------------------------
    // Fixed field values and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  PCB_DEVICE_CATEGORY_CODE    = 8'h06;
    localparam logic [7:0]  PCB_FUNCTION_CATEGORY_CODE  = 8'h04;
    localparam logic [7:0]  PCB_PROGRAM_INTERFACE_CODE  = 8'h00;
    localparam logic [7:0]  PCB_CACHE_LINE_SIZE_RESET   = 8'h00;
    localparam logic [7:0]  PCB_PRIMARY_LAT_TIMER_VALUE = 8'h00;
    localparam logic [7:0]  PCB_HEADER_TYPE_VALUE       = 8'h01;
    localparam logic [7:0]  PCB_SELF_TEST_VALUE         = 8'h00;
    localparam logic [19:0] PCB_WINDOW_BASE_RESET       = 20'h00000;
    localparam logic [7:0]  PCB_WINDOW_RSVD_VALUE       = 8'h00;
    localparam logic        PCB_WINDOW_PREFETCH_FLAG    = 1'b0;
    localparam logic [1:0]  PCB_WINDOW_TYPE_CODE        = 2'b00;
    localparam logic        PCB_SPACE_KIND_FLAG         = 1'b0;

    // ------------------------------------------------------------------
    // Field positions of the control window base
    // ------------------------------------------------------------------
    localparam int PCB_WINDOW_BASE_LSB = 12;
    localparam int PCB_WINDOW_BASE_MSB = 31;

    // ------------------------------------------------------------------
    // Prefetch sizing
    // ------------------------------------------------------------------
    localparam int          PCB_PREFETCH_WIDTH     = 6;
    localparam logic [7:0]  PCB_PREFETCH_LIMIT_DW  = 8'h20;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } pcb_cfg_req_type;

    typedef struct packed {
        logic        ack;
        logic        hit;
        logic [31:0] rdata;
    } pcb_cfg_rsp_type;

endpackage

// file: hdl/pcb_prefetch_sizer.sv
`timescale 1ns/10ps

module pcb_prefetch_sizer
    import pcb_pkg::*;
#(
    parameter int SB_WIDTH = PCB_PREFETCH_WIDTH
) (
    input  wire logic                          core_clk,
    input  wire logic                          reset,
    input  wire logic                          use_line_size,
    input  wire logic [7:0]                    line_size,
    input  wire logic [SB_WIDTH-1:0]           sideband_dwords,
    output logic      [PCB_PREFETCH_WIDTH-1:0] prefetch_dwords_q
);

    // Oversized line sizes collapse onto the limit
    function automatic logic [PCB_PREFETCH_WIDTH-1:0] clamp_line(
        input logic [7:0] size
    );
        logic [7:0] lim;
        lim = (size > PCB_PREFETCH_LIMIT_DW) ? PCB_PREFETCH_LIMIT_DW : size;
        return lim[PCB_PREFETCH_WIDTH-1:0];
    endfunction

    logic [PCB_PREFETCH_WIDTH-1:0] prefetch_dwords_d;

    always_comb begin
        if (use_line_size) begin
            prefetch_dwords_d = clamp_line(line_size);
        end else begin
            prefetch_dwords_d = PCB_PREFETCH_WIDTH'(sideband_dwords);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            prefetch_dwords_q <= '0;
        end else begin
            prefetch_dwords_q <= prefetch_dwords_d;
        end
    end

endmodule

// file: hdl/pcb_config_header.sv
`timescale 1ns/10ps

module pcb_config_header
    import pcb_pkg::*;
#(
    parameter int         SB_WIDTH          = PCB_PREFETCH_WIDTH,
    // Arbitrary neutral value, replaced per silicon build
    parameter logic [7:0] SILICON_REVISION  = 8'h00
) (
    input  wire logic                          core_clk,
    input  wire logic                          reset,
    input  wire pcb_cfg_req_type               cfg_req,
    output pcb_cfg_rsp_type                    cfg_rsp_q,
    input  wire logic                          cache_line_check_enable,
    input  wire logic                          window_zero_enable,
    input  wire logic [SB_WIDTH-1:0]           sideband_dwords,
    input  wire logic                          mem_addr_valid,
    input  wire logic [31:0]                   mem_addr,
    output logic                               window_hit_q,
    output logic      [PCB_PREFETCH_WIDTH-1:0] prefetch_dwords_q,
    output logic      [19:0]                   window_base_q
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic [11:0] dword_addr;
    logic        sel_class;
    logic        sel_misc;
    logic        sel_window;
    logic        sel_any;
    logic        wr_strobe;

    assign dword_addr = {cfg_req.addr[11:2], 2'b00};
    assign sel_class  = (dword_addr == PCB_OFS_CLASS_AND_REVISION);
    assign sel_misc   = (dword_addr == PCB_OFS_CACHE_LINE_SIZE);
    assign sel_window = (dword_addr == PCB_OFS_CONTROL_WINDOW_BASE);
    assign sel_any    = sel_class | sel_misc | sel_window;
    assign wr_strobe  = cfg_req.valid & cfg_req.write;

    // ------------------------------------------------------------------
    // Cache line size
    // ------------------------------------------------------------------
    logic [7:0] cache_line_size_q;
    logic [7:0] cache_line_size_d;

    // The power-of-two restriction is the programmer's burden; the
    // register stores whatever is written so it also serves as scratch.
    always_comb begin
        cache_line_size_d = cache_line_size_q;
        if (wr_strobe && sel_misc && cfg_req.byte_en[0]) begin
            cache_line_size_d = cfg_req.wdata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cache_line_size_q <= PCB_CACHE_LINE_SIZE_RESET;
        end else begin
            cache_line_size_q <= cache_line_size_d;
        end
    end

    // ------------------------------------------------------------------
    // Control window base
    // ------------------------------------------------------------------
    logic [19:0] window_base_d;
    logic [31:0] window_wmask;

    // Byte lanes map onto the base field; lane one only reaches 15:12
    assign window_wmask = {{8{cfg_req.byte_en[3]}},
                           {8{cfg_req.byte_en[2]}},
                           {4{cfg_req.byte_en[1]}},
                           12'h000};

    always_comb begin
        window_base_d = window_base_q;
        if (!window_zero_enable) begin
            // Held at zero so a stale base cannot claim cycles later
            window_base_d = PCB_WINDOW_BASE_RESET;
        end else if (wr_strobe && sel_window) begin
            window_base_d =
                (window_base_q &
                 ~window_wmask[PCB_WINDOW_BASE_MSB:PCB_WINDOW_BASE_LSB]) |
                (cfg_req.wdata[PCB_WINDOW_BASE_MSB:PCB_WINDOW_BASE_LSB] &
                 window_wmask[PCB_WINDOW_BASE_MSB:PCB_WINDOW_BASE_LSB]);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            window_base_q <= PCB_WINDOW_BASE_RESET;
        end else begin
            window_base_q <= window_base_d;
        end
    end

    // ------------------------------------------------------------------
    // Window claim
    // ------------------------------------------------------------------
    logic window_hit_d;

    assign window_hit_d = window_zero_enable & mem_addr_valid &
        (mem_addr[PCB_WINDOW_BASE_MSB:PCB_WINDOW_BASE_LSB] ==
         window_base_q);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            window_hit_q <= 1'b0;
        end else begin
            window_hit_q <= window_hit_d;
        end
    end

    // ------------------------------------------------------------------
    // Read data assembly
    // ------------------------------------------------------------------
    logic [31:0] class_word;
    logic [31:0] misc_word;
    logic [31:0] window_word;
    logic [31:0] rdata_d;

    assign class_word  = {PCB_DEVICE_CATEGORY_CODE,
                          PCB_FUNCTION_CATEGORY_CODE,
                          PCB_PROGRAM_INTERFACE_CODE,
                          SILICON_REVISION};
    assign misc_word   = {PCB_SELF_TEST_VALUE,
                          PCB_HEADER_TYPE_VALUE,
                          PCB_PRIMARY_LAT_TIMER_VALUE,
                          cache_line_size_q};
    assign window_word = {window_base_q,
                          PCB_WINDOW_RSVD_VALUE,
                          PCB_WINDOW_PREFETCH_FLAG,
                          PCB_WINDOW_TYPE_CODE,
                          PCB_SPACE_KIND_FLAG};

    // Read-only words have no storage, so writes to them fall away
    always_comb begin
        rdata_d = 32'h00000000;
        if (cfg_req.valid && !cfg_req.write) begin
            if (sel_class) begin
                rdata_d = class_word;
            end else if (sel_misc) begin
                rdata_d = misc_word;
            end else if (sel_window) begin
                rdata_d = window_word;
            end
        end
    end

    // ------------------------------------------------------------------
    // Response
    // ------------------------------------------------------------------
    // Every request is answered, writes to fixed fields included, so the
    // link side never waits on an error path.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cfg_rsp_q <= '0;
        end else begin
            cfg_rsp_q.ack   <= cfg_req.valid;
            cfg_rsp_q.hit   <= cfg_req.valid & sel_any;
            cfg_rsp_q.rdata <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Prefetch sizing
    // ------------------------------------------------------------------
    pcb_prefetch_sizer #(
        .SB_WIDTH          (SB_WIDTH)
    ) u_sizer (
        .core_clk          (core_clk),
        .reset             (reset),
        .use_line_size     (cache_line_check_enable),
        .line_size         (cache_line_size_q),
        .sideband_dwords   (sideband_dwords),
        .prefetch_dwords_q (prefetch_dwords_q)
    );

endmodule

// file: bench/pcb_config_header_props.sv
`timescale 1ns/10ps

module pcb_config_header_props
    import pcb_pkg::*;
#(
    parameter int         SB_WIDTH         = PCB_PREFETCH_WIDTH,
    parameter logic [7:0] SILICON_REVISION = 8'h00
) (
    input wire logic                          core_clk,
    input wire logic                          reset,
    input wire pcb_cfg_req_type               cfg_req,
    input wire pcb_cfg_rsp_type               cfg_rsp_q,
    input wire logic                          cache_line_check_enable,
    input wire logic                          window_zero_enable,
    input wire logic [SB_WIDTH-1:0]           sideband_dwords,
    input wire logic                          mem_addr_valid,
    input wire logic [31:0]                   mem_addr,
    input wire logic                          window_hit_q,
    input wire logic [PCB_PREFETCH_WIDTH-1:0] prefetch_dwords_q,
    input wire logic [19:0]                   window_base_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic rd_class;
    logic rd_misc;
    logic rd_base;
    assign rd_class = cfg_req.valid && !cfg_req.write
        && cfg_req.addr[11:2] == 10'h002;
    assign rd_misc = cfg_req.valid && !cfg_req.write
        && cfg_req.addr[11:2] == 10'h003;
    assign rd_base = cfg_req.valid && !cfg_req.write
        && cfg_req.addr[11:2] == 10'h004;

    ack_pulse_a: assert property (
        1 |=> cfg_rsp_q.ack == $past(cfg_req.valid))
        else $error("config ack does not follow request");
    class_word_a: assert property (rd_class |=> cfg_rsp_q.hit
        && cfg_rsp_q.rdata == {8'h06, 8'h04, 8'h00, SILICON_REVISION})
        else $error("class word read wrong");
    fixed_bytes_a: assert property (rd_misc |=>
        cfg_rsp_q.rdata[31:8] == 24'h000100)
        else $error("fixed header bytes read wrong");
    base_low_a: assert property (
        rd_base |=> cfg_rsp_q.rdata[11:0] == 12'h000)
        else $error("window base low bits not zero");
    base_read_a: assert property (rd_base |=>
        cfg_rsp_q.rdata[31:12] == $past(window_base_q))
        else $error("window base read differs from base");
    base_locked_a: assert property (
        !window_zero_enable |=> window_base_q == 20'h0)
        else $error("window base not zero while disabled");
    sideband_size_a: assert property (!cache_line_check_enable |=>
        prefetch_dwords_q == $past(sideband_dwords))
        else $error("prefetch not taken from sideband");
    clamp_limit_a: assert property (cache_line_check_enable |=>
        prefetch_dwords_q <= 6'h20)
        else $error("prefetch above limit");
    window_claim_a: assert property (
        1 |=> window_hit_q == $past(mem_addr_valid
        && window_zero_enable && mem_addr[31:12] == window_base_q))
        else $error("window hit wrong");
endmodule

bind pcb_config_header pcb_config_header_props #(
    .SB_WIDTH(SB_WIDTH),
    .SILICON_REVISION(SILICON_REVISION)
) i_pcb_config_header_props (
    .core_clk(core_clk), .reset(reset), .cfg_req(cfg_req),
    .cfg_rsp_q(cfg_rsp_q), .cache_line_check_enable(cache_line_check_enable),
    .window_zero_enable(window_zero_enable),
    .sideband_dwords(sideband_dwords), .mem_addr_valid(mem_addr_valid),
    .mem_addr(mem_addr), .window_hit_q(window_hit_q),
    .prefetch_dwords_q(prefetch_dwords_q), .window_base_q(window_base_q)
);

// file: bench/pcb_host_model.sv
`timescale 1ns/10ps

module pcb_host_model
    import pcb_pkg::*;
(
    input  wire logic            core_clk,
    input  wire pcb_cfg_rsp_type cfg_rsp_q,
    output pcb_cfg_req_type      cfg_req
);
    initial cfg_req = '0;

    // One request per call; released lines carry the inverse of the last
    // value so a stale address or data word can never pass as a new one
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [3:0] be, input logic [31:0] wd,
                        output pcb_cfg_rsp_type rsp);
        int n;
        @(negedge core_clk);
        cfg_req = {1'b1, wr, a, be, wd};
        @(negedge core_clk);
        cfg_req = {1'b0, ~cfg_req[49:0]};
        n = 0;
        while (cfg_rsp_q.ack !== 1'b1 && n < 4) begin
            n++;
            @(negedge core_clk);
        end
        rsp = cfg_rsp_q;
    endtask
endmodule

// file: bench/pcb_config_header_tb.sv
`timescale 1ns/10ps

module pcb_config_header_tb
    import pcb_pkg::*;
;
    // Arbitrary revision value for this build
    localparam logic [7:0] REV = 8'h5a;
    logic            core_clk, reset, cle, wze, mem_addr_valid;
    logic [5:0]      sideband_dwords, prefetch_dwords_q;
    logic [31:0]     mem_addr;
    logic [19:0]     window_base_q;
    logic            window_hit_q;
    pcb_cfg_req_type cfg_req;
    pcb_cfg_rsp_type cfg_rsp_q, rsp;
    int              num_errors = 0, tests_run = 0, cycles = 0;

    pcb_config_header #(.SILICON_REVISION(REV)) i_pcb_config_header (
        .core_clk(core_clk), .reset(reset), .cfg_req(cfg_req),
        .cfg_rsp_q(cfg_rsp_q), .cache_line_check_enable(cle),
        .window_zero_enable(wze), .sideband_dwords(sideband_dwords),
        .mem_addr_valid(mem_addr_valid), .mem_addr(mem_addr),
        .window_hit_q(window_hit_q), .prefetch_dwords_q(prefetch_dwords_q),
        .window_base_q(window_base_q));
    pcb_host_model i_pcb_host_model (
        .core_clk(core_clk), .cfg_rsp_q(cfg_rsp_q), .cfg_req(cfg_req));

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic x(input logic w, input logic [11:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
        i_pcb_host_model.xfer(w, a, be, wd, rsp);
        chk_bit(rsp.ack, 1'b1);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic t_fixed();
        x(1'b1, 12'h008, 4'hf, 32'hffffffff);
        x(1'b1, 12'h00c, 4'he, 32'hffffffff);
        x(1'b0, 12'h008, 4'h0, 32'h0);
        chk_word(rsp.rdata, {8'h06, 8'h04, 8'h00, REV});
        chk_bit(rsp.hit, 1'b1);
        x(1'b0, 12'h00c, 4'h0, 32'h0);
        chk_word(rsp.rdata, 32'h00010000);
        x(1'b0, 12'h014, 4'h0, 32'h0);
        chk_bit(rsp.hit, 1'b0);
        chk_word(rsp.rdata, 32'h0);
        $display("fixed words test done");
    endtask
    task automatic t_line();
        x(1'b1, 12'h00c, 4'h1, 32'h00000040);
        x(1'b0, 12'h00c, 4'h0, 32'h0);
        chk_word(rsp.rdata, 32'h00010040);
        chk_word({26'h0, prefetch_dwords_q}, 32'h0b);
        cle = 1'b1;
        @(negedge core_clk);
        chk_word({26'h0, prefetch_dwords_q}, 32'h20);
        x(1'b1, 12'h00c, 4'h1, 32'h00000010);
        @(negedge core_clk);
        chk_word({26'h0, prefetch_dwords_q}, 32'h10);
        cle = 1'b0;
        $display("line size test done");
    endtask
    task automatic t_window();
        x(1'b1, 12'h010, 4'hf, 32'hffffffff);
        x(1'b0, 12'h010, 4'h0, 32'h0);
        chk_word(rsp.rdata, 32'h0);
        wze = 1'b1;
        x(1'b1, 12'h010, 4'hf, 32'hffffffff);
        x(1'b0, 12'h010, 4'h0, 32'h0);
        chk_word(rsp.rdata, 32'hfffff000);
        mem_addr = 32'hfffff123;
        mem_addr_valid = 1'b1;
        @(negedge core_clk);
        chk_bit(window_hit_q, 1'b1);
        wze = 1'b0;
        @(negedge core_clk);
        chk_word({12'h0, window_base_q}, 32'h0);
        mem_addr_valid = 1'b0;
        $display("window test done");
    endtask

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        reset = 1'b1;
        cle = 1'b0;
        wze = 1'b0;
        sideband_dwords = 6'h0b;
        mem_addr_valid = 1'b0;
        mem_addr = 32'h0;
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        t_fixed();
        t_line();
        t_window();
        wrap_up();
    end
endmodule
